// ===== hdl/icu_input_capture_unit.sv
// Input capture unit: two capture channels sampling a shared 16-bit timer.
// Assumes pins synchronous to ref_clk, an AHB-Lite master, one slave on the bus.
//
// The AHB-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ns

// How it works
// - a qualifying event loads the full 16-bit shared timer into the capture value.
// - mode select picks falling, rising, every 4th or every 16th rising edge.
// - each capture sets the event flag; only software clears it.
// - a new capture overwrites the stored value even if unread.
// - prescaler counter held at zero while off or not in capture mode.
// - any reset clears the prescaler counter.
// - switching prescaler setting directly keeps the counter, may give spurious capture.
// - a mode change may flag a false capture; software masks and clears it.
// - with the pin as output, port writes reach the edge detector.
// - two independent identical channels, each with own control, value, pin, flag.
module icu_input_capture_unit
   import icu_pkg::*;
#(
   parameter int CHANNELS = icu_pkg::ICU_CHANNELS
) (
   input  wire logic                            ref_clk,
   input  wire logic                            resetn,
   input  wire logic [31:0]                     haddr,
   input  wire logic [1:0]                      htrans,
   input  wire logic                            hwrite,
   input  wire logic [2:0]                      hsize,
   input  wire logic [31:0]                     hwdata,
   input  wire logic                            hsel,
   input  wire logic                            hready,
   output logic      [31:0]                     hrdata,
   output logic                                 hreadyout,
   output logic                                 hresp,
   input  wire logic [icu_pkg::ICU_TIMER_W-1:0] sharedTimer,
   input  wire icu_pkg::icu_pin_s [1:0]         capturePin,
   output logic      [1:0]                      captureEvent,
   output logic                                 irq
);
   import icu_pkg::*;

   // ==========================================================
   // Reset release
   logic       rstSync1_ff;
   logic       rstSync2_ff;
   wire logic  rstN = rstSync2_ff;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rstSync1_ff <= 1'b0;
         rstSync2_ff <= 1'b0;
      end else begin
         rstSync1_ff <= 1'b1;
         rstSync2_ff <= rstSync1_ff;
      end
   end

   // ==========================================================
   // AHB-Lite slave
   logic        wrPend_ff;
   logic [7:0]  wrAddr_ff;
   logic [31:0] hrdata_ff;

   wire logic  accept  = hsel && hready && htrans[1];
   wire logic  rdReq   = accept && !hwrite;
   wire logic  wrReq   = accept && hwrite;
   wire logic  wrCtrl0 = wrPend_ff && (wrAddr_ff == ICU_OFF_CTRL0);
   wire logic  wrCtrl1 = wrPend_ff && (wrAddr_ff == ICU_OFF_CTRL1);
   wire logic  wrStat  = wrPend_ff && (wrAddr_ff == ICU_OFF_STATUS);
   wire logic  wrMask  = wrPend_ff && (wrAddr_ff == ICU_OFF_MASK);

   // Bus responses: no wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_ff;

   // Write request pending for the data phase
   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         wrPend_ff <= 1'b0;
      end else begin
         wrPend_ff <= wrReq;
      end
   end

   // Address of the accepted transfer
   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         wrAddr_ff <= 8'h00;
      end else if (accept) begin
         wrAddr_ff <= haddr[7:0];
      end
   end

   // ==========================================================
   // Control, mask and interrupt
   logic      [1:0]  wrCtrl;
   logic      [1:0]  clrReq;
   wire logic [1:0]  capHit;
   wire logic [1:0]  flagVec;
   wire logic [3:0]  ctrlVal [2];
   wire icu_cap_s    capVal  [2];
   logic      [1:0]  mask_ff;

   assign wrCtrl = {wrCtrl1, wrCtrl0};
   assign clrReq = wrStat ? hwdata[1:0] : 2'h0;

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         mask_ff <= ICU_MASK_RST;
      end else if (wrMask) begin
         mask_ff <= hwdata[1:0];
      end
   end

   assign irq          = |(flagVec & mask_ff);
   assign captureEvent = flagVec;

   // ==========================================================
   // Read mux
   logic        selCtrl0;
   logic        selCtrl1;
   logic        selCap0;
   logic        selCap1;
   logic        selStat;
   logic        selMask;
   logic        selTimer;

   assign selCtrl0 = (haddr[7:0] == ICU_OFF_CTRL0);
   assign selCtrl1 = (haddr[7:0] == ICU_OFF_CTRL1);
   assign selCap0  = (haddr[7:0] == ICU_OFF_CAP0);
   assign selCap1  = (haddr[7:0] == ICU_OFF_CAP1);
   assign selStat  = (haddr[7:0] == ICU_OFF_STATUS);
   assign selMask  = (haddr[7:0] == ICU_OFF_MASK);
   assign selTimer = (haddr[7:0] == ICU_OFF_TIMER);

   logic [31:0] rdCtrl0;
   logic [31:0] rdCtrl1;
   logic [31:0] rdCap0;
   logic [31:0] rdCap1;
   logic [31:0] rdStat;
   logic [31:0] rdMask;
   logic [31:0] rdTimer;

   assign rdCtrl0 = {28'h0, ctrlVal[0]};
   assign rdCtrl1 = {28'h0, ctrlVal[1]};
   assign rdCap0  = {16'h0, capVal[0]};
   assign rdCap1  = {16'h0, capVal[1]};
   assign rdStat  = {30'h0, flagVec};
   assign rdMask  = {30'h0, mask_ff};
   assign rdTimer = {16'h0, sharedTimer};

   logic [31:0] rdMux;
   assign rdMux = ({32{selCtrl0}} & rdCtrl0) |
                  ({32{selCtrl1}} & rdCtrl1) |
                  ({32{selCap0}}  & rdCap0)  |
                  ({32{selCap1}}  & rdCap1)  |
                  ({32{selStat}}  & rdStat)  |
                  ({32{selMask}}  & rdMask)  |
                  ({32{selTimer}} & rdTimer);

   // Read data register holds until the next read
   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         hrdata_ff <= 32'h0000_0000;
      end else if (rdReq) begin
         hrdata_ff <= rdMux;
      end
   end

   // ==========================================================
   // Capture channels
   for (genvar ch = 0; ch < 2; ch++) begin : gChan
      logic [3:0] chCtrl_ff;
      logic       evtFlag_ff;
      logic       nxt_evtFlag;
      icu_cap_s   capReg_ff;
      logic       sync1_ff;
      logic       sync2_ff;
      logic       prev_ff;
      logic [3:0] presc_ff;
      logic [3:0] nxt_presc;
      logic       pinLevel;
      logic       rise;
      logic       fall;
      logic       capMode;
      logic       modeFall;
      logic       modeRise;
      logic       modeDiv;
      logic [3:0] lastCount;
      logic       prescLast;
      logic       divEdge;
      logic       hitFall;
      logic       hitRise;
      logic       hitDiv;
      logic       clrBit;
      logic       setBit;

      // Register view of this channel
      assign ctrlVal[ch] = chCtrl_ff;
      assign capVal[ch]  = capReg_ff;
      assign flagVec[ch] = evtFlag_ff;

      // Port latch reaches the detector while the pin is driven
      assign pinLevel = capturePin[ch].pinDirectionBit ? capturePin[ch].pinIn
                                                       : capturePin[ch].portOut;

      // Edges of the synchronised level
      assign rise = sync2_ff && !prev_ff;
      assign fall = !sync2_ff && prev_ff;

      // Mode decode
      assign capMode  = (chCtrl_ff[3:2] == 2'b01);
      assign modeFall = capMode && (chCtrl_ff[1:0] == 2'b00);
      assign modeRise = capMode && (chCtrl_ff[1:0] == 2'b01);
      assign modeDiv  = capMode && chCtrl_ff[1];

      // Edge prescaler; a setting change keeps the count
      assign lastCount = chCtrl_ff[0] ? ICU_DIV16_LAST : ICU_DIV4_LAST;
      assign prescLast = (presc_ff >= lastCount);
      assign divEdge   = modeDiv && rise;

      // Qualifying events
      assign hitFall    = modeFall && fall;
      assign hitRise    = modeRise && rise;
      assign hitDiv     = divEdge && prescLast;
      assign capHit[ch] = hitFall || hitRise || hitDiv;

      always_comb begin
         nxt_presc = presc_ff;
         if (!capMode) begin
            nxt_presc = ICU_PRESC_RST;
         end else if (divEdge) begin
            nxt_presc = prescLast ? ICU_PRESC_RST : presc_ff + 4'h1;
         end
      end

      // Control register of this channel
      always_ff @(posedge ref_clk or negedge rstN) begin
         if (!rstN) begin
            chCtrl_ff <= ICU_CTRL_RST;
         end else if (wrCtrl[ch]) begin
            chCtrl_ff <= hwdata[3:0];
         end
      end

      // Strobes of this channel
      assign clrBit = clrReq[ch];
      assign setBit = capHit[ch];

      // Event flag: a capture wins over a same-cycle clear
      assign nxt_evtFlag = (evtFlag_ff && !clrBit) || setBit;
      always_ff @(posedge ref_clk or negedge rstN) begin
         if (!rstN) begin
            evtFlag_ff <= ICU_FLAG_RST[ch];
         end else begin
            evtFlag_ff <= nxt_evtFlag;
         end
      end

      // Two-stage pin synchroniser
      always_ff @(posedge ref_clk or negedge rstN) begin
         if (!rstN) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
         end else begin
            sync1_ff <= pinLevel;
            sync2_ff <= sync1_ff;
         end
      end

      // Edge history
      always_ff @(posedge ref_clk or negedge rstN) begin
         if (!rstN) begin
            prev_ff <= 1'b0;
         end else begin
            prev_ff <= sync2_ff;
         end
      end

      // Edge prescaler counter
      always_ff @(posedge ref_clk or negedge rstN) begin
         if (!rstN) begin
            presc_ff <= ICU_PRESC_RST;
         end else begin
            presc_ff <= nxt_presc;
         end
      end

      // Capture value: a new capture overwrites an unread one
      always_ff @(posedge ref_clk or negedge rstN) begin
         if (!rstN) begin
            capReg_ff <= '0;
         end else if (setBit) begin
            capReg_ff <= sharedTimer;
         end
      end
   end

endmodule

// ===== hdl/icu_pkg.sv
// Input capture unit package: register map, field layout, mode codes.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
package icu_pkg;

   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] ICU_OFF_CTRL0   = 8'h00;
   localparam logic [7:0] ICU_OFF_CTRL1   = 8'h04;
   localparam logic [7:0] ICU_OFF_CAP0    = 8'h08;
   localparam logic [7:0] ICU_OFF_CAP1    = 8'h0c;
   localparam logic [7:0] ICU_OFF_STATUS  = 8'h10;
   localparam logic [7:0] ICU_OFF_MASK    = 8'h14;
   localparam logic [7:0] ICU_OFF_TIMER   = 8'h18;

   // ==========================================================
   // Field layout and reset values
   localparam int         ICU_MODE_W      = 4;
   localparam int         ICU_TIMER_W     = 16;
   localparam int         ICU_CHANNELS    = 2;
   localparam int         ICU_PRESC_W     = 4;
   localparam logic [3:0] ICU_CTRL_RST    = 4'h0;
   localparam logic [1:0] ICU_FLAG_RST    = 2'h0;
   localparam logic [1:0] ICU_MASK_RST    = 2'h0;
   localparam logic [3:0] ICU_PRESC_RST   = 4'h0;
   localparam logic [3:0] ICU_DIV4_LAST   = 4'h3;
   localparam logic [3:0] ICU_DIV16_LAST  = 4'hf;

   // ==========================================================
   // Capture mode select codes
   typedef enum logic [3:0] {
      ICU_MODE_OFF   = 4'b0000,
      ICU_MODE_FALL  = 4'b0100,
      ICU_MODE_RISE  = 4'b0101,
      ICU_MODE_RISE4 = 4'b0110,
      ICU_MODE_RISE16 = 4'b0111
   } icu_mode_e;

   // Pin group for one channel
   typedef struct packed {
      logic pinIn;
      logic portOut;
      logic pinDirectionBit;
   } icu_pin_s;

   // Captured value split in high and low bytes
   typedef struct packed {
      logic [7:0] captureValueHigh;
      logic [7:0] captureValueLow;
   } icu_cap_s;

endpackage

// ===== tb/icu_chk.sv
// Checker: bus answer, flag and capture timing of the capture unit.
// Assumes a bind to icu_input_capture_unit.
`timescale 1ns/1ns
module icu_chk
   import icu_pkg::*;
(
   input wire logic             ref_clk,
   input wire logic             resetn,
   input wire logic [31:0]      haddr,
   input wire logic [1:0]       htrans,
   input wire logic             hwrite,
   input wire logic [31:0]      hwdata,
   input wire logic             hsel,
   input wire logic             hready,
   input wire logic [31:0]      hrdata,
   input wire logic             hreadyout,
   input wire logic             hresp,
   input wire logic [15:0]      sharedTimer,
   input wire icu_pin_s [1:0]   capturePin,
   input wire logic [1:0]       captureEvent,
   input wire logic             irq
);
   // =====
   // Helpers
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   logic       wStat_ff;
   wire        rdT = hsel & hready & htrans[1] & !hwrite;
   wire        wrS = hsel & hready & htrans[1] & hwrite & (haddr[7:0] == ICU_OFF_STATUS);
   wire [1:0]  lvl = {capturePin[1].pinDirectionBit ? capturePin[1].pinIn : capturePin[1].portOut,
                      capturePin[0].pinDirectionBit ? capturePin[0].pinIn : capturePin[0].portOut};
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) wStat_ff <= 1'b0;
      else wStat_ff <= wrS;
   end
   // =====
   // Properties
   AST_READY: assert property (hreadyout && !hresp) else $error("bus not ready or not OKAY");
   AST_IRQ_SRC: assert property (irq |-> captureEvent != 2'h0) else $error("irq without flag");
   AST_STICKY0:
      assert property ($fell(captureEvent[0]) |-> $past(wStat_ff && hwdata[0])) else $error("flag0 lost");
   AST_STICKY1:
      assert property ($fell(captureEvent[1]) |-> $past(wStat_ff && hwdata[1])) else $error("flag1 lost");
   AST_CAUSE0:
      assert property ($rose(captureEvent[0]) |-> $past(lvl[0],3) != $past(lvl[0],4)) else $error("flag0 no edge");
   AST_CAUSE1:
      assert property ($rose(captureEvent[1]) |-> $past(lvl[1],3) != $past(lvl[1],4)) else $error("flag1 no edge");
   AST_STATUS_RD:
      assert property (rdT && haddr[7:0] == ICU_OFF_STATUS |=> hrdata == {30'h0, $past(captureEvent)})
      else $error("status read wrong");
   AST_TIMER_RD:
      assert property (rdT && haddr[7:0] == ICU_OFF_TIMER |=> hrdata == {16'h0, $past(sharedTimer)})
      else $error("timer read wrong");
   AST_UNMAPPED: assert property (rdT && haddr[7:0] == 8'h1c |=> hrdata == 32'h0) else $error("unmapped read");
   COV_CAP: cover property ($rose(captureEvent[0]));
   COV_IRQ: cover property ($rose(irq));
   COV_CLR: cover property ($fell(captureEvent[0]));
endmodule

// ===== tb/icu_pin_model.sv
// Partner: external signals at the two capture pins.
// Assumes calls from the bench right after a rising edge.
`timescale 1ns/1ns
module icu_pin_model
   import icu_pkg::*;
(
   input wire logic       ref_clk,
   output icu_pin_s [1:0] capturePin
);
   logic [1:0] lvl, port, dir;
   initial begin
      lvl = 2'h0;
      port = 2'h0;
      dir = 2'h3;
   end
   // Pad follows the port latch while driven as output
   always_comb for (int c = 0; c < 2; c++) capturePin[c] = {dir[c] ? lvl[c] : port[c], port[c], dir[c]};
   task setDir(input int c, input logic d);
      @(posedge ref_clk);
      dir[c] <= d;
   endtask
   task pulses(input int c, input int n, input int gap);
      repeat (n) begin
         @(posedge ref_clk);
         if (dir[c]) lvl[c] <= 1'b1; else port[c] <= 1'b1;
         repeat (gap) @(posedge ref_clk);
         if (dir[c]) lvl[c] <= 1'b0; else port[c] <= 1'b0;
         repeat (gap) @(posedge ref_clk);
      end
   endtask
endmodule

// ===== tb/tb_icu_input_capture_unit.sv
// Bench: register tests of the capture unit through AHB-Lite.
// Assumes icu_pin_model drives the pins.
`timescale 1ns/1ns
module tb_icu_input_capture_unit;
   import icu_pkg::*;
   logic ref_clk, resetn, hwrite, hsel, hreadyout, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, captureEvent;
   logic [2:0] hsize;
   logic [15:0] sharedTimer;
   icu_pin_s [1:0] capturePin;
   int error_cnt, cmp_count;
   icu_mode_e modes[4] = '{ICU_MODE_FALL, ICU_MODE_RISE, ICU_MODE_RISE4, ICU_MODE_RISE16};
   int cnt[4] = '{1, 1, 4, 16};
   icu_input_capture_unit icu_input_capture_unit_i (.ref_clk, .resetn, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hsel, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .sharedTimer,
      .capturePin, .captureEvent, .irq);
   icu_pin_model icu_pin_model_i (.ref_clk, .capturePin);
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // =====
   // Tasks
   task conclude;
      if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task waitRdy;
      int n;
      n = 0;
      do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'b1 && n < 20);
      if (n >= 20) begin error_cnt++; conclude; end
   endtask
   task bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
      @(posedge ref_clk);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      waitRdy;
      htrans <= 2'h0;
      hwdata <= wd;
      waitRdy;
      rd = hrdata;
   endtask
   task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      bus(a, 1'b0, 32'h0);
      check(nm, rd, e);
   endtask
   task arm(input logic [7:0] a, input logic [3:0] m);
      bus(a, 1'b1, {28'h0, m});
      bus(ICU_OFF_STATUS, 1'b1, 32'h3);
   endtask
   task pulse(input int c, input int n);
      icu_pin_model_i.pulses(c, n, 2);
      repeat (4) @(posedge ref_clk);
   endtask
   // =====
   // Main sequence
   initial begin
      {resetn, htrans, haddr, hwrite, hwdata, error_cnt, cmp_count} = '0;
      hsize = 3'h2;
      hsel = 1'b1;
      sharedTimer = 16'ha5c3;
      repeat (12) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rdchk("status", ICU_OFF_STATUS, 32'h0);
      rdchk("mask", ICU_OFF_MASK, 32'h0);
      bus(8'h1c, 1'b1, 32'hffff);
      rdchk("unmapped", 8'h1c, 32'h0);
      rdchk("timer", ICU_OFF_TIMER, 32'ha5c3);
      for (int i = 0; i < 4; i++) begin
         bus(ICU_OFF_CTRL0, 1'b1, 32'h0);
         arm(ICU_OFF_CTRL0, modes[i]);
         pulse(0, cnt[i] - 1);
         rdchk("early", ICU_OFF_STATUS, 32'h0);
         sharedTimer <= 16'h3c5a + 16'(i);
         pulse(0, 1);
         rdchk("flag", ICU_OFF_STATUS, 32'h1);
         rdchk("cap0", ICU_OFF_CAP0, {16'h0, 16'h3c5a + 16'(i)});
      end
      repeat (20) @(posedge ref_clk);
      rdchk("sticky", ICU_OFF_STATUS, 32'h1);
      bus(ICU_OFF_MASK, 1'b1, 32'h1);
      bus(ICU_OFF_CTRL0, 1'b1, 32'h0);
      arm(ICU_OFF_CTRL0, ICU_MODE_RISE);
      sharedTimer <= 16'h7e81;
      pulse(0, 1);
      sharedTimer <= 16'h18e7;
      pulse(0, 1);
      rdchk("overwrite", ICU_OFF_CAP0, 32'h18e7);
      check("irq", {31'h0, irq}, 32'h1);
      bus(ICU_OFF_MASK, 1'b1, 32'h0);
      repeat (2) @(negedge ref_clk);
      check("irq masked", {31'h0, irq}, 32'h0);
      bus(ICU_OFF_STATUS, 1'b1, 32'h1);
      rdchk("cleared", ICU_OFF_STATUS, 32'h0);
      bus(ICU_OFF_CTRL0, 1'b1, 32'h0);
      arm(ICU_OFF_CTRL0, ICU_MODE_RISE16);
      pulse(0, 3);
      arm(ICU_OFF_CTRL0, ICU_MODE_RISE4);
      pulse(0, 1);
      rdchk("spurious", ICU_OFF_STATUS, 32'h1);
      pulse(0, 2);
      bus(ICU_OFF_CTRL0, 1'b1, 32'h0);
      arm(ICU_OFF_CTRL0, ICU_MODE_RISE4);
      pulse(0, 2);
      rdchk("off clears", ICU_OFF_STATUS, 32'h0);
      resetn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      arm(ICU_OFF_CTRL0, ICU_MODE_RISE4);
      pulse(0, 3);
      rdchk("reset clears", ICU_OFF_STATUS, 32'h0);
      icu_pin_model_i.setDir(1, 1'b0);
      arm(ICU_OFF_CTRL1, ICU_MODE_RISE);
      rdchk("ctrl1", ICU_OFF_CTRL1, {28'h0, ICU_MODE_RISE});
      sharedTimer <= 16'hc33c;
      pulse(1, 1);
      rdchk("ch1 flag", ICU_OFF_STATUS, 32'h2);
      rdchk("cap1", ICU_OFF_CAP1, 32'hc33c);
      conclude;
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      error_cnt++;
      conclude;
   end
endmodule
bind icu_input_capture_unit icu_chk icu_chk_i (.ref_clk, .resetn, .haddr, .htrans, .hwrite,
   .hwdata, .hsel, .hready, .hrdata, .hreadyout, .hresp, .sharedTimer, .capturePin,
   .captureEvent, .irq);
